// ==== src/efi_cfg.svh ====
// register indices, field positions and constants of the e1 event block
// assumes: included by its bare name from the top module only
`ifndef EFI_CFG_SVH
`define EFI_CFG_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EFI_IDX_MODE_A 10'h04d
`define EFI_IDX_MODE_B 10'h04e
`define EFI_IDX_SYNC_ST 10'h04f
`define EFI_IDX_EN_A 10'h050
`define EFI_IDX_EN_B 10'h051
`define EFI_IDX_FLG_A 10'h052
`define EFI_IDX_FLG_B 10'h053
`define EFI_IDX_SA_EN 10'h05c
`define EFI_IDX_SA_FLG 10'h05d
`define EFI_IDX_OH_ST 10'h05f
`define EFI_IDX_OH_EN 10'h060
`define EFI_IDX_OH_FLG 10'h061

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EFI_RST_BYTE 8'h00
`define EFI_RST_WIN 3'h7

// ----------------------------------------------------------------------
// sync group bits (status, flags a, enable a)
// ----------------------------------------------------------------------
`define EFI_A_BASIC 0
`define EFI_A_CRCMF 1
`define EFI_A_OFFL 2
`define EFI_A_IWORK 3
`define EFI_A_SIGMF 4

// ----------------------------------------------------------------------
// event group bits (flags b, enable b)
// ----------------------------------------------------------------------
`define EFI_B_CMFPAT 0
`define EFI_B_AWERR 1
`define EFI_B_CRC4 2
`define EFI_B_SMFPAT 3
`define EFI_B_AMOVE 4
`define EFI_B_CMFST 5
`define EFI_B_SUBST 6
`define EFI_B_SMFST 7

// ----------------------------------------------------------------------
// overhead group bits (status uses bits 3..5 shifted down by 3)
// ----------------------------------------------------------------------
`define EFI_O_FEBE 0
`define EFI_O_TFEBE 1
`define EFI_O_TCRC 2
`define EFI_O_ALRM 3
`define EFI_O_STDY 4
`define EFI_O_LINK 5

// ----------------------------------------------------------------------
// national bit group: bits 0..4 word change sa4..sa8, bit 5 sa6 code
// ----------------------------------------------------------------------
`define EFI_S_CODE 5

// ----------------------------------------------------------------------
// sa6 match codes
// ----------------------------------------------------------------------
`define EFI_SA6_C0 12'h888
`define EFI_SA6_C1 12'haaa
`define EFI_SA6_C2 12'hccc
`define EFI_SA6_C3 12'heee
`define EFI_SA6_C4 12'hfff

`endif

// ==== src/efi_pkg.sv ====
// types shared by the e1 event interrupt block
// assumes: nothing beyond the constants header
`default_nettype none

package efi_pkg;
  typedef logic [7:0] efi_byte_t;
  typedef logic [9:0] efi_idx_t;
endpackage

`default_nettype wire

// ==== src/efi_top.sv ====
// e1 receive event collector: status, latched flags, enables, interrupt
// assumes: framer event and status inputs are on clk_in; avalon-mm host
//
// Function
// RULE_01: link id when two of three sa7 zero
// RULE_02: link id detection halted without basic alignment
// RULE_03: status bit follows its source condition
// RULE_04: any status edge sets its flag
// RULE_05: event without status sets flag directly
// RULE_06: flags latched until host write clears them
// RULE_07: flag reaches interrupt only when enabled
// RULE_08: basic alignment loss has status, flag, enable
// RULE_09: crc multiframe loss has status, flag, enable
// RULE_10: signaling multiframe loss has status, flag, enable
// RULE_11: interworking has status, flag, enable
// RULE_12: offline search has status, flag, enable
// RULE_13: alignment move sets flag with enable
// RULE_14: alignment word errors set flag with enable
// RULE_15: multiframe pattern errors set separate flags
// RULE_16: crc4 and far block errors set flags
// RULE_17: alarm plus far error has status, flag, enable
// RULE_18: steady far error has status, flag, enable
// RULE_19: multiframe start positions set separate flags
// RULE_20: five codeword change flags, sa4 to sa8
// RULE_21: sa6 code match sets flag with enable
// RULE_22: terminal far and crc errors set flags
// RULE_23: link id has status, flag, enable
// RULE_24: interrupt low while any enabled flag set
`include "efi_cfg.svh"
`default_nettype none

module efi_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // avalon-mm slave
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // framer status levels
  input wire logic basic_align_lost_in,
  input wire logic crc_mf_lost_in,
  input wire logic sig_mf_lost_in,
  input wire logic interwork_in,
  input wire logic offline_search_in,
  input wire logic alarm_plus_far_err_in,
  input wire logic steady_far_err_in,
  // framer event pulses
  input wire logic align_move_in,
  input wire logic align_word_err_in,
  input wire logic crc_mf_pattern_err_in,
  input wire logic sig_mf_pattern_err_in,
  input wire logic crc4_err_in,
  input wire logic far_block_err_in,
  input wire logic terminal_far_err_in,
  input wire logic terminal_crc_err_in,
  input wire logic crc_mf_start_in,
  input wire logic crc_submf_start_in,
  input wire logic sig_mf_start_in,
  // national bits: per nfas frame, and per sub multiframe codewords
  input wire logic natbit_stb_in,
  input wire logic sa6_bit_in,
  input wire logic sa7_bit_in,
  input wire logic natbit_word_stb_in,
  input wire logic [19:0] natbit_word_in,
  // framer mode and interrupt
  output logic [7:0] frame_mode_a_out,
  output logic [7:0] frame_mode_b_out,
  output logic irq_n_out
);

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  wire efi_pkg::efi_idx_t idx = avs_address_in[11:2];
  wire go = (avs_read_in | avs_write_in) & wait_q;
  wire wr = avs_write_in & ~wait_q & avs_byteenable_in[0];
  wire efi_pkg::efi_byte_t wd = avs_writedata_in[7:0];
  wire wr_mode_a = wr & (idx == `EFI_IDX_MODE_A);
  wire wr_mode_b = wr & (idx == `EFI_IDX_MODE_B);
  wire wr_en_a = wr & (idx == `EFI_IDX_EN_A);
  wire wr_en_b = wr & (idx == `EFI_IDX_EN_B);
  wire wr_flg_a = wr & (idx == `EFI_IDX_FLG_A);
  wire wr_flg_b = wr & (idx == `EFI_IDX_FLG_B);
  wire wr_sa_en = wr & (idx == `EFI_IDX_SA_EN);
  wire wr_sa_flg = wr & (idx == `EFI_IDX_SA_FLG);
  wire wr_oh_en = wr & (idx == `EFI_IDX_OH_EN);
  wire wr_oh_flg = wr & (idx == `EFI_IDX_OH_FLG);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  efi_pkg::efi_byte_t mode_a_q, mode_b_q;
  efi_pkg::efi_byte_t en_a_q, en_b_q, sa_en_q, oh_en_q;
  efi_pkg::efi_byte_t flg_a_q, flg_b_q, sa_flg_q, oh_flg_q;
  efi_pkg::efi_byte_t flg_a_d, flg_b_d, sa_flg_d, oh_flg_d;
  logic [4:0] st_a_q;
  logic [2:0] st_oh_q;
  logic [2:0] win_q;
  logic [11:0] sa6_sh_q;
  logic [3:0] sa6_bits_q;
  logic [11:0] sa6_nib_q;
  logic [1:0] nib_cnt_q;
  logic [19:0] word_prev_q;
  logic word_seen_q;
  logic irq_n_q;

  // --------------------------------------------------------------------
  // status levels
  // --------------------------------------------------------------------
  wire [4:0] st_a_d = {sig_mf_lost_in, interwork_in, offline_search_in,
                       crc_mf_lost_in, basic_align_lost_in}; // RULE_03
  wire basic_lost = basic_align_lost_in;
  // window holding the last three sa7 bits
  wire [2:0] win_d = basic_lost ? `EFI_RST_WIN :
                     natbit_stb_in ? {win_q[1:0], sa7_bit_in} :
                     win_q; // RULE_02
  wire link_d = ~basic_lost &
                ((~win_d[0] & ~win_d[1]) | (~win_d[0] & ~win_d[2]) |
                 (~win_d[1] & ~win_d[2])); // RULE_01
  wire [2:0] st_oh_d = {link_d, steady_far_err_in,
                        alarm_plus_far_err_in}; // RULE_03

  // --------------------------------------------------------------------
  // status edges and direct events
  // --------------------------------------------------------------------
  wire [4:0] chg_a = st_a_q ^ st_a_d; // RULE_04
  wire [2:0] chg_oh = st_oh_q ^ st_oh_d; // RULE_04

  // sa6 match on 12 sliding bits and on three codewords
  wire [11:0] sh_d = {sa6_sh_q[10:0], sa6_bit_in};
  wire [11:0] nib_d = {sa6_nib_q[7:0], natbit_word_in[11:8]};
  function automatic logic sa6_hit(input logic [11:0] v);
    sa6_hit = (v == `EFI_SA6_C0) | (v == `EFI_SA6_C1) |
              (v == `EFI_SA6_C2) | (v == `EFI_SA6_C3) |
              (v == `EFI_SA6_C4);
  endfunction
  wire bit_hit = natbit_stb_in & ~basic_lost & (&sa6_bits_q[3:0]) &
                 sa6_hit(sh_d); // RULE_21
  wire nib_hit = natbit_word_stb_in & ~crc_mf_lost_in &
                 nib_cnt_q[1] & sa6_hit(nib_d); // RULE_21

  // codeword change per sa4..sa8
  logic [4:0] word_chg;
  always_comb begin
    word_chg = 5'h00;
    for (int i = 0; i < 5; i++) begin
      word_chg[i] = natbit_word_stb_in & word_seen_q &
                    (natbit_word_in[4*i +: 4] !=
                     word_prev_q[4*i +: 4]); // RULE_20
    end
  end

  wire [7:0] set_a = {3'h0, chg_a}; // RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
  wire [7:0] set_b = {sig_mf_start_in, crc_submf_start_in,
                      crc_mf_start_in, align_move_in,
                      sig_mf_pattern_err_in, crc4_err_in,
                      align_word_err_in,
                      crc_mf_pattern_err_in}; // RULE_05 RULE_13 RULE_14 RULE_15 RULE_16 RULE_19
  wire [7:0] set_oh = {2'h0, chg_oh,
                       terminal_crc_err_in, terminal_far_err_in,
                       far_block_err_in}; // RULE_16 RULE_17 RULE_18 RULE_22 RULE_23
  wire [7:0] set_sa = {2'h0, bit_hit | nib_hit, word_chg};

  // --------------------------------------------------------------------
  // flag update: a set in the clearing cycle wins
  // --------------------------------------------------------------------
  always_comb begin
    flg_a_d = (flg_a_q & ~({8{wr_flg_a}} & wd)) | set_a; // RULE_06
    flg_b_d = (flg_b_q & ~({8{wr_flg_b}} & wd)) | set_b; // RULE_06
    oh_flg_d = (oh_flg_q & ~({8{wr_oh_flg}} & wd)) | set_oh; // RULE_06
    sa_flg_d = (sa_flg_q & ~({8{wr_sa_flg}} & wd)) | set_sa; // RULE_06
  end

  wire irq_any = |(flg_a_q & en_a_q) | |(flg_b_q & en_b_q) |
                 |(oh_flg_q & oh_en_q) | |(sa_flg_q & sa_en_q); // RULE_07

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  efi_pkg::efi_byte_t rd;
  always_comb begin
    unique case (idx)
      `EFI_IDX_MODE_A: rd = mode_a_q;
      `EFI_IDX_MODE_B: rd = mode_b_q;
      `EFI_IDX_SYNC_ST: rd = {3'h0, st_a_q};
      `EFI_IDX_EN_A: rd = en_a_q;
      `EFI_IDX_EN_B: rd = en_b_q;
      `EFI_IDX_FLG_A: rd = flg_a_q;
      `EFI_IDX_FLG_B: rd = flg_b_q;
      `EFI_IDX_SA_EN: rd = sa_en_q;
      `EFI_IDX_SA_FLG: rd = sa_flg_q;
      `EFI_IDX_OH_ST: rd = {5'h00, st_oh_q};
      `EFI_IDX_OH_EN: rd = oh_en_q;
      `EFI_IDX_OH_FLG: rd = oh_flg_q;
      default: rd = `EFI_RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------
  // bus handshake: one wait cycle per access
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~go;
      if (go) begin
        rdata_q <= {24'h00_0000, rd};
      end
    end
  end

  // --------------------------------------------------------------------
  // host written registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mode_a_q <= `EFI_RST_BYTE;
      mode_b_q <= `EFI_RST_BYTE;
      en_a_q <= `EFI_RST_BYTE;
      en_b_q <= `EFI_RST_BYTE;
      sa_en_q <= `EFI_RST_BYTE;
      oh_en_q <= `EFI_RST_BYTE;
    end else begin
      if (wr_mode_a) mode_a_q <= wd;
      if (wr_mode_b) mode_b_q <= wd;
      if (wr_en_a) en_a_q <= {3'h0, wd[4:0]};
      if (wr_en_b) en_b_q <= wd;
      if (wr_sa_en) sa_en_q <= {2'h0, wd[5:0]};
      if (wr_oh_en) oh_en_q <= {2'h0, wd[5:0]};
    end
  end

  // --------------------------------------------------------------------
  // status, flags and interrupt
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_a_q <= 5'h00;
      st_oh_q <= 3'h0;
      flg_a_q <= `EFI_RST_BYTE;
      flg_b_q <= `EFI_RST_BYTE;
      oh_flg_q <= `EFI_RST_BYTE;
      sa_flg_q <= `EFI_RST_BYTE;
      irq_n_q <= 1'b1;
    end else begin
      st_a_q <= st_a_d;
      st_oh_q <= st_oh_d;
      flg_a_q <= flg_a_d;
      flg_b_q <= flg_b_d;
      oh_flg_q <= oh_flg_d;
      sa_flg_q <= sa_flg_d;
      irq_n_q <= ~irq_any; // RULE_24
    end
  end

  // --------------------------------------------------------------------
  // national bit history
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      win_q <= `EFI_RST_WIN;
      sa6_sh_q <= 12'h000;
      sa6_bits_q <= 4'h0;
      sa6_nib_q <= 12'h000;
      nib_cnt_q <= 2'h0;
      word_prev_q <= 20'h0_0000;
      word_seen_q <= 1'b0;
    end else begin
      win_q <= win_d; // RULE_02
      if (basic_lost) begin
        sa6_bits_q <= 4'h0;
      end else if (natbit_stb_in) begin
        sa6_sh_q <= sh_d;
        // counts up to four fresh bits before a match may fire
        sa6_bits_q <= {sa6_bits_q[2:0], 1'b1};
      end
      if (crc_mf_lost_in) begin
        nib_cnt_q <= 2'h0;
      end else if (natbit_word_stb_in) begin
        sa6_nib_q <= nib_d;
        if (!nib_cnt_q[1]) nib_cnt_q <= nib_cnt_q + 2'h1;
      end
      if (natbit_word_stb_in) begin
        word_prev_q <= natbit_word_in;
        word_seen_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign frame_mode_a_out = mode_a_q;
  assign frame_mode_b_out = mode_b_q;
  assign irq_n_out = irq_n_q;

endmodule

`default_nettype wire

// ==== sim/efi_framer_model.sv ====
// framer side model: status levels, event pulses, national bit strobes
// assumes: bench requests change just after the rising clock edge
`default_nettype none

module efi_framer_model (
  // clock
  input wire logic clk_in,
  // requests from the bench
  input wire logic [6:0] lvl_in,
  input wire logic [10:0] ev_in,
  input wire logic nb_in,
  input wire logic sa6_in,
  input wire logic sa7_in,
  input wire logic wd_in,
  input wire logic [19:0] word_in,
  // lines into the block
  output logic [6:0] lvl_out,
  output logic [10:0] ev_out,
  output logic nb_out,
  output logic sa6_out,
  output logic sa7_out,
  output logic wd_out,
  output logic [19:0] word_out
);
  // bits are valid only beside their strobe; elsewhere they are inverted
  always_ff @(posedge clk_in) begin
    lvl_out <= lvl_in;
    ev_out <= ev_in;
    nb_out <= nb_in;
    wd_out <= wd_in;
    sa6_out <= nb_in ? sa6_in : ~sa6_in;
    sa7_out <= nb_in ? sa7_in : ~sa7_in;
    word_out <= wd_in ? word_in : ~word_in;
  end
endmodule

`default_nettype wire

// ==== sim/efi_monitor.sv ====
// checker for the host port, status readback and interrupt release
// assumes: bound to efi_top, one clock domain
`default_nettype none

module efi_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // host port
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic irq_n_out,
  // framer levels
  input wire logic basic_align_lost_in,
  input wire logic crc_mf_lost_in,
  input wire logic sig_mf_lost_in,
  input wire logic interwork_in,
  input wire logic offline_search_in,
  input wire logic alarm_plus_far_err_in,
  input wire logic steady_far_err_in
);
  wire logic done = !avs_waitrequest_out;
  wire logic rd_done = avs_read_in && done;
  wire logic [9:0] idx = avs_address_in[11:2];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ----
  // assertions
  // ----
  wait_one_a: assert property (done |=> !done)
    else $error("waitrequest low longer than one cycle");
  accept_a: assert property ((avs_read_in || avs_write_in) && !done |=> done)
    else $error("request not answered after one wait cycle");
  idle_wait_a: assert property (!(avs_read_in || avs_write_in) |=> !done)
    else $error("waitrequest dropped without a request");
  unmapped_zero_a: assert property (rd_done && idx == 10'h3ff |->
    avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  sync_status_a: assert property (rd_done && idx == 10'h04f |->
    avs_readdata_out == {27'h0, $past(sig_mf_lost_in, 2),
    $past(interwork_in, 2), $past(offline_search_in, 2),
    $past(crc_mf_lost_in, 2), $past(basic_align_lost_in, 2)})
    else $error("sync status does not follow its sources");
  ovh_status_a: assert property (rd_done && idx == 10'h05f |->
    avs_readdata_out[1:0] == {$past(steady_far_err_in, 2),
    $past(alarm_plus_far_err_in, 2)})
    else $error("overhead status does not follow its sources");
  link_hold_a: assert property (rd_done && idx == 10'h05f &&
    $past(basic_align_lost_in, 2) |-> !avs_readdata_out[2])
    else $error("link id status set without basic alignment");
  irq_release_a: assert property ($rose(irq_n_out) |->
    $past(avs_write_in && done, 2))
    else $error("interrupt released without a host write");
endmodule

bind efi_top efi_monitor efi_monitor_inst (.clk_in, .rstn_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .irq_n_out, .basic_align_lost_in,
  .crc_mf_lost_in, .sig_mf_lost_in, .interwork_in, .offline_search_in,
  .alarm_plus_far_err_in, .steady_far_err_in);

`default_nettype wire

// ==== sim/efi_top_bench.sv ====
// self-checking bench for the e1 event interrupt block
// assumes: efi_top fed by the framer model, host port driven here
`default_nettype none

module efi_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rstn_in, rd, wr, wq, irq, nb, s6, s7, wds;
  logic m_nb, m_s6, m_s7, m_wds;
  logic [11:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdat;
  logic [7:0] ma, mb;
  logic [6:0] lvl, m_lvl;
  logic [10:0] ev, m_ev;
  logic [19:0] wdat, m_wdat;
  int error_cnt = 0;
  int tests_run = 0;

  efi_framer_model efi_framer_model_inst (.clk_in(clk_in), .lvl_in(lvl),
    .ev_in(ev), .nb_in(nb), .sa6_in(s6), .sa7_in(s7), .wd_in(wds),
    .word_in(wdat), .lvl_out(m_lvl), .ev_out(m_ev), .nb_out(m_nb),
    .sa6_out(m_s6), .sa7_out(m_s7), .wd_out(m_wds), .word_out(m_wdat));

  efi_top efi_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .basic_align_lost_in(m_lvl[0]), .crc_mf_lost_in(m_lvl[1]),
    .offline_search_in(m_lvl[2]), .interwork_in(m_lvl[3]),
    .sig_mf_lost_in(m_lvl[4]), .alarm_plus_far_err_in(m_lvl[5]),
    .steady_far_err_in(m_lvl[6]), .crc_mf_pattern_err_in(m_ev[0]),
    .align_word_err_in(m_ev[1]), .crc4_err_in(m_ev[2]),
    .sig_mf_pattern_err_in(m_ev[3]), .align_move_in(m_ev[4]),
    .crc_mf_start_in(m_ev[5]), .crc_submf_start_in(m_ev[6]),
    .sig_mf_start_in(m_ev[7]), .far_block_err_in(m_ev[8]),
    .terminal_far_err_in(m_ev[9]), .terminal_crc_err_in(m_ev[10]),
    .natbit_stb_in(m_nb), .sa6_bit_in(m_s6), .sa7_bit_in(m_s7),
    .natbit_word_stb_in(m_wds), .natbit_word_in(m_wdat),
    .frame_mode_a_out(ma), .frame_mode_b_out(mb), .irq_n_out(irq));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ----
  // host tasks
  // ----
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] ix,
      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= {ix, 2'h0};
    wd <= {24'h0, d};
    @(posedge clk_in);
    while (wq !== 1'b0) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        end_of_test;
      end
      @(posedge clk_in);
    end
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wreg(input logic [9:0] ix, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, ix, d, q);
  endtask

  task automatic rchk(input logic [9:0] ix, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, ix, 8'h00, q);
    chk(q, e);
  endtask

  task automatic nbit(input logic a6, input logic a7);
    nb <= 1'b1;
    s6 <= a6;
    s7 <= a7;
    @(posedge clk_in);
    nb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wstb(input logic [19:0] v);
    wds <= 1'b1;
    wdat <= v;
    @(posedge clk_in);
    wds <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [9:0] rw[6] = '{10'h04d, 10'h04e, 10'h050, 10'h051, 10'h05c,
      10'h060};
    foreach (rw[i]) begin
      rchk(rw[i], 8'h00);
      wreg(rw[i], 8'h15);
      rchk(rw[i], 8'h15);
    end
    chk(ma, 8'h15);
    chk(mb, 8'h15);
    wreg(10'h050, 8'hff);
    rchk(10'h050, 8'h1f);
    foreach (rw[i]) wreg(rw[i], 8'h00);
    // a write without the low byte lane must leave the register alone
    be <= 4'he;
    wreg(10'h04d, 8'hff);
    be <= 4'hf;
    rchk(10'h04d, 8'h00);
    wreg(10'h04f, 8'hff);
    rchk(10'h04f, 8'h00);
    wreg(10'h3ff, 8'hff);
    rchk(10'h3ff, 8'h00);
    rchk(10'h053, 8'h00);
    $display("register test done");
  endtask

  task automatic t_levels;
    logic [9:0] sr, fr;
    logic [7:0] sb, fb;
    for (int i = 0; i < 7; i++) begin
      sr = (i < 5) ? 10'h04f : 10'h05f;
      fr = (i < 5) ? 10'h052 : 10'h061;
      sb = (i < 5) ? 8'h01 << i : 8'h01 << (i - 5);
      fb = (i < 5) ? 8'h01 << i : 8'h01 << (i - 2);
      lvl[i] <= 1'b1;
      repeat (3) @(posedge clk_in);
      rchk(sr, sb);
      rchk(fr, fb);
      wreg(fr, fb);
      rchk(fr, 8'h00);
      lvl[i] <= 1'b0;
      repeat (3) @(posedge clk_in);
      rchk(sr, 8'h00);
      rchk(fr, fb);
      wreg(fr, fb);
    end
    $display("status level test done");
  endtask

  task automatic t_events;
    logic [9:0] fr;
    logic [7:0] fb;
    for (int i = 0; i < 11; i++) begin
      fr = (i < 8) ? 10'h053 : 10'h061;
      fb = (i < 8) ? 8'h01 << i : 8'h01 << (i - 8);
      ev <= 11'h001 << i;
      @(posedge clk_in);
      ev <= 11'h000;
      repeat (3) @(posedge clk_in);
      rchk(fr, fb);
      rchk(fr, fb);
      wreg(fr, fb);
      rchk(fr, 8'h00);
    end
    $display("event test done");
  endtask

  task automatic t_irq;
    ev <= 11'h010;
    @(posedge clk_in);
    ev <= 11'h100;
    @(posedge clk_in);
    ev <= 11'h000;
    repeat (3) @(posedge clk_in);
    chk({7'h00, irq}, 8'h01);
    wreg(10'h051, 8'h10);
    wreg(10'h060, 8'h01);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h00);
    wreg(10'h053, 8'h10);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h00);
    wreg(10'h061, 8'h01);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h01);
    wreg(10'h051, 8'h00);
    wreg(10'h060, 8'h00);
    $display("interrupt test done");
  endtask

  task automatic t_link;
    logic [7:0] sa = 8'h0a;
    logic [7:0] lost = 8'h30;
    logic [7:0] st = 8'h84;
    for (int k = 0; k < 8; k++) begin
      lvl[0] <= lost[k];
      repeat (2) @(posedge clk_in);
      nbit(1'b0, sa[k]);
      repeat (2) @(posedge clk_in);
      rchk(10'h05f, {5'h00, st[k], 2'h0});
    end
    rchk(10'h061, 8'h20);
    wreg(10'h061, 8'h20);
    wreg(10'h052, 8'h01);
    $display("link id test done");
  endtask

  task automatic t_nat;
    logic [19:0] w = 20'h0;
    logic [11:0] c = 12'haaa;
    for (int i = 11; i >= 0; i--) nbit(c[i], 1'b1);
    repeat (2) @(posedge clk_in);
    rchk(10'h05d, 8'h20);
    wreg(10'h05d, 8'h20);
    wstb(w);
    rchk(10'h05d, 8'h00);
    for (int x = 0; x < 5; x++) begin
      w[4 * x +: 4] = 4'h1;
      wstb(w);
      rchk(10'h05d, 8'h01 << x);
      wreg(10'h05d, 8'h01 << x);
    end
    w[11:8] = 4'ha;
    repeat (3) wstb(w);
    rchk(10'h05d, 8'h24);
    wreg(10'h05d, 8'h24);
    $display("national bit test done");
  endtask

  initial begin
    rstn_in = 1'b0;
    {rd, wr, nb, s6, s7, wds} = 6'h00;
    adr = 12'h000;
    be = 4'hf;
    wd = 32'h0;
    lvl = 7'h00;
    ev = 11'h000;
    wdat = 20'h0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_regs;
    t_levels;
    t_events;
    t_irq;
    t_link;
    t_nat;
    end_of_test;
  end
endmodule

`default_nettype wire
